// ---- design/scg_pkg.sv ----
// Purpose: Constants for the serial video checkfield generator
// Assumes: 10-bit words, 8.2 fixed point (integer part in bits 9:2)
// Notes: Line numbers are 1-based as counted by the video timing source
package scg_pkg;

  // Word values
  localparam logic [9:0] EQ_CHROMA_WORD = 10'h300;   // 192.00
  localparam logic [9:0] EQ_LUMA_WORD = 10'h198;     // 102.00
  localparam logic [9:0] PLL_CHROMA_WORD = 10'h200;  // 128.00
  localparam logic [9:0] PLL_LUMA_WORD = 10'h110;    // 68.00
  localparam logic [9:0] POL_WORD = 10'h190;         // 100.00
  localparam logic [9:0] POL_WORD_SWAPPED = 10'h200; // 128.00

  // Word positions within the active line
  localparam logic [11:0] LAST_WORD_POS = 12'hEFF;   // 3839
  localparam logic [11:0] POL_WORD_POS = 12'h001;

  // Scanning format select
  localparam logic [1:0] FMT_1125_I = 2'h0;
  localparam logic [1:0] FMT_1250_I = 2'h1;
  localparam logic [1:0] FMT_1080_I = 2'h2;  // Interlaced or segmented_frame_transport
  localparam logic [1:0] FMT_1080_P = 2'h3;

  // Per field or progressive frame: first line, last equalizer line (low end of range), last PLL line
  localparam logic [10:0] F1_FIRST_1125 = 11'h029;  // 41
  localparam logic [10:0] F1_EQ_LO_1125 = 11'h127;  // 295
  localparam logic [10:0] F1_LAST_1125 = 11'h22D;   // 557
  localparam logic [10:0] F2_FIRST_1125 = 11'h25B;  // 603
  localparam logic [10:0] F2_EQ_LO_1125 = 11'h35A;  // 858
  localparam logic [10:0] F2_LAST_1125 = 11'h460;   // 1120
  localparam logic [10:0] F1_FIRST_1250 = 11'h02D;  // 45
  localparam logic [10:0] F1_EQ_LO_1250 = 11'h149;  // 329
  localparam logic [10:0] F1_LAST_1250 = 11'h26C;   // 620
  localparam logic [10:0] F2_FIRST_1250 = 11'h29E;  // 670
  localparam logic [10:0] F2_EQ_LO_1250 = 11'h3BA;  // 954
  localparam logic [10:0] F2_LAST_1250 = 11'h4DD;   // 1245
  localparam logic [10:0] F1_FIRST_1080I = 11'h015; // 21
  localparam logic [10:0] F1_EQ_LO_1080I = 11'h11F; // 287
  localparam logic [10:0] F1_LAST_1080I = 11'h230;  // 560
  localparam logic [10:0] F2_FIRST_1080I = 11'h248; // 584
  localparam logic [10:0] F2_EQ_LO_1080I = 11'h352; // 850
  localparam logic [10:0] F2_LAST_1080I = 11'h463;  // 1123
  localparam logic [10:0] FIRST_1080P = 11'h02A;    // 42
  localparam logic [10:0] EQ_LO_1080P = 11'h242;    // 578
  localparam logic [10:0] LAST_1080P = 11'h461;     // 1121

  // Width of the switch-over ranges minus one (7 for 1125 and 1080P, 6 otherwise)
  localparam logic [2:0] SPAN_WIDE = 3'h7;
  localparam logic [2:0] SPAN_NARROW = 3'h6;

  // Reset values
  localparam logic [9:0] RST_WORD = 10'h040;

  // Output content selector
  typedef enum logic [1:0] {SCG_PASS, SCG_EQ, SCG_PLL} scg_zone_t;

endpackage

// ---- design/scg_checkfield_gen.sv ----
// Purpose: Checkfield test picture generator ahead of the serial scrambler
// Assumes: Timing source gives line number, frame start, active flag and word position
// Notes: One word per clk_sys; output is registered, one cycle behind the input
`timescale 1ns/1ps

module scg_checkfield_gen
  import scg_pkg::*;
#(
  parameter int WORD_W = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Configuration levels, held static while enabled
  input wire logic gen_enable,
  input wire logic [1:0] format_sel,
  input wire logic [2:0] switch_offset,
  input wire logic eq_swap,
  input wire logic pll_swap,
  // Video from the timing source
  input wire logic [WORD_W-1:0] src_word,
  input wire logic [10:0] src_line,
  input wire logic [11:0] src_word_pos,
  input wire logic src_active,
  input wire logic src_frame_start,
  // Video to the scrambler and serializer
  output logic [WORD_W-1:0] out_word,
  output logic out_active,
  output logic out_polarity_frame
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Word handed to the scrambler
    logic [WORD_W-1:0] word;
    // Active flag, aligned with the word
    logic active;
    // Frame parity; high on frames that carry the polarity word
    logic frame_toggle;
  } scg_state_t;

  scg_state_t st;
  scg_state_t next_st;

  // ----------------------------------------------------------------
  // Layout helpers
  // ----------------------------------------------------------------
  // Line numbers are taken as the timing source counts them; the block never
  // counts lines itself, so a source that numbers from zero shifts every window.
  // One field's checkfield window. The switch line is a low end plus a span, so
  // the chosen line can sit anywhere in the allowed range without more constants.
  typedef struct packed {
    logic valid;
    logic [10:0] first;
    logic [10:0] eq_lo;
    logic [2:0] span;
    logic [10:0] last;
  } scg_window_t;

  // Clamp the chosen switch line into the allowed range so any offset is legal
  function automatic logic [10:0] eq_last(input logic [10:0] lo, input logic [2:0] span,
                                          input logic [2:0] ofs);
    logic [2:0] o;
    o = (ofs > span) ? span : ofs;
    eq_last = lo + {8'h00, o};
  endfunction

  // Map a line to its content zone
  function automatic scg_zone_t zone_of(input logic [10:0] ln, input logic [10:0] f,
                                        input logic [10:0] e, input logic [10:0] l);
    if (ln >= f && ln <= e) begin
      zone_of = SCG_EQ;
    end else if (ln > e && ln <= l) begin
      zone_of = SCG_PLL;
    end else begin
      zone_of = SCG_PASS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Field windows per format
  // ----------------------------------------------------------------
  // Field 1, or the whole frame of a progressive format; also the polarity line
  function automatic scg_window_t window_f1(input logic [1:0] fmt);
    window_f1.valid = 1'b0;
    window_f1.first = 11'h000;
    window_f1.eq_lo = 11'h000;
    window_f1.span = 3'h0;
    window_f1.last = 11'h000;
    case (fmt)
      FMT_1125_I: begin
        // Equalizer from line 41, switch within 295..302, PLL to 557
        // Eight candidate switch lines, so the wide span applies
        window_f1.valid = 1'b1;
        window_f1.first = F1_FIRST_1125;
        window_f1.eq_lo = F1_EQ_LO_1125;
        window_f1.span = SPAN_WIDE;
        window_f1.last = F1_LAST_1125;
      end
      FMT_1250_I: begin
        // Equalizer from line 45, switch within 329..335, PLL to 620
        // Seven candidate switch lines, so the narrow span applies
        window_f1.valid = 1'b1;
        window_f1.first = F1_FIRST_1250;
        window_f1.eq_lo = F1_EQ_LO_1250;
        window_f1.span = SPAN_NARROW;
        window_f1.last = F1_LAST_1250;
      end
      FMT_1080_I: begin
        // Equalizer from line 21, switch within 287..293, PLL to 560
        // Segmented frames share this layout with the interlaced ones
        window_f1.valid = 1'b1;
        window_f1.first = F1_FIRST_1080I;
        window_f1.eq_lo = F1_EQ_LO_1080I;
        window_f1.span = SPAN_NARROW;
        window_f1.last = F1_LAST_1080I;
      end
      FMT_1080_P: begin
        // Equalizer from line 42, switch within 578..585, PLL to 1121
        // One window covers the whole progressive frame
        window_f1.valid = 1'b1;
        window_f1.first = FIRST_1080P;
        window_f1.eq_lo = EQ_LO_1080P;
        window_f1.span = SPAN_WIDE;
        window_f1.last = LAST_1080P;
      end
      default: begin
        window_f1.valid = 1'b0;
      end
    endcase
  endfunction

  // Field 2 of interlaced or segmented formats; a progressive frame has none,
  // and an invalid window keeps its zero lines from matching anything
  function automatic scg_window_t window_f2(input logic [1:0] fmt);
    window_f2.valid = 1'b0;
    window_f2.first = 11'h000;
    window_f2.eq_lo = 11'h000;
    window_f2.span = 3'h0;
    window_f2.last = 11'h000;
    case (fmt)
      FMT_1125_I: begin
        // Equalizer from line 603, switch within 858..865, PLL to 1120
        // Same offset as field 1, so the switch stays consistent
        window_f2.valid = 1'b1;
        window_f2.first = F2_FIRST_1125;
        window_f2.eq_lo = F2_EQ_LO_1125;
        window_f2.span = SPAN_WIDE;
        window_f2.last = F2_LAST_1125;
      end
      FMT_1250_I: begin
        // Equalizer from line 670, switch within 954..960, PLL to 1245
        // Same offset as field 1, so the switch stays consistent
        window_f2.valid = 1'b1;
        window_f2.first = F2_FIRST_1250;
        window_f2.eq_lo = F2_EQ_LO_1250;
        window_f2.span = SPAN_NARROW;
        window_f2.last = F2_LAST_1250;
      end
      FMT_1080_I: begin
        // Equalizer from line 584, switch within 850..856, PLL to 1123
        // Second field or second segment of the frame
        window_f2.valid = 1'b1;
        window_f2.first = F2_FIRST_1080I;
        window_f2.eq_lo = F2_EQ_LO_1080I;
        window_f2.span = SPAN_NARROW;
        window_f2.last = F2_LAST_1080I;
      end
      FMT_1080_P: begin
        // Progressive frames carry a single field
        window_f2.valid = 1'b0;
      end
      default: begin
        window_f2.valid = 1'b0;
      end
    endcase
  endfunction

  // Zone of a line inside one window; a window that the format lacks never matches
  function automatic scg_zone_t zone_in_window(input logic [10:0] ln, input scg_window_t w,
                                               input logic [2:0] ofs);
    if (w.valid) begin
      zone_in_window = zone_of(ln, w.first, eq_last(w.eq_lo, w.span, ofs), w.last);
    end else begin
      zone_in_window = SCG_PASS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Line layout decode
  // ----------------------------------------------------------------
  scg_window_t win_f1;
  scg_window_t win_f2;
  scg_zone_t zone_f1;
  scg_zone_t zone_f2;
  scg_zone_t zone;
  logic first_line;

  // Window constants for the selected format
  always_comb begin
    win_f1 = window_f1(format_sel);
    win_f2 = window_f2(format_sel);
  end

  // Both fields use the same offset, so the switch line matches in every field
  always_comb begin
    zone_f1 = zone_in_window(src_line, win_f1, switch_offset);
    zone_f2 = zone_in_window(src_line, win_f2, switch_offset);
    // Windows never overlap, so field 1 simply takes precedence
    zone = (zone_f1 != SCG_PASS) ? zone_f1 : zone_f2;
  end

  // Polarity word sits on the first active line of the frame, which is field 1;
  // field 2 never carries it, so the bias flips once per frame, not per field
  assign first_line = win_f1.valid && (src_line == win_f1.first);

  // ----------------------------------------------------------------
  // Word selection
  // ----------------------------------------------------------------
  logic is_luma;
  logic in_line;
  logic pol_hit;
  logic [9:0] pol_value;
  logic [9:0] eq_word;
  logic [9:0] pll_word;
  logic [9:0] pat_word;

  // Pick one half of a word pair; the swap trades which half goes where
  function automatic logic [9:0] pair_word(input logic luma, input logic swap,
                                           input logic [9:0] luma_val,
                                           input logic [9:0] chroma_val);
    pair_word = (luma ^ swap) ? luma_val : chroma_val;
  endfunction

  // Odd positions are luma, even are chroma (Cb, Y, Cr, Y)
  assign is_luma = src_word_pos[0];
  assign in_line = (src_word_pos <= LAST_WORD_POS);

  // One-bit change on alternate frames flips the parity of the field bit sum, so the
  // equalizer bias changes sign every frame whatever the unmodified sum is
  always_comb begin
    pol_hit = st.frame_toggle && first_line && (src_word_pos == POL_WORD_POS);
    pol_value = eq_swap ? POL_WORD_SWAPPED : POL_WORD;
  end

  // Both pattern words are formed every cycle; the zone decides which one is used
  always_comb begin
    eq_word = pair_word(is_luma, eq_swap, EQ_LUMA_WORD, EQ_CHROMA_WORD);
    pll_word = pair_word(is_luma, pll_swap, PLL_LUMA_WORD, PLL_CHROMA_WORD);
  end

  // Values are 8.2 codes; runs of 19-and-1 and 20-and-20 appear only after the
  // downstream scrambler lines up, which about half a field of lines makes likely
  always_comb begin
    pat_word = 10'h000;
    case (zone)
      SCG_EQ: begin
        pat_word = pol_hit ? pol_value : eq_word;
      end
      SCG_PLL: begin
        pat_word = pll_word;
      end
      default: begin
        pat_word = 10'h000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic insert;

  // Checkfield replaces only in-zone active words; the rest passes through untouched.
  // Configuration is sampled every word: changing it mid-frame breaks the
  // frame-to-frame consistency of the switch line, so hold it while enabled.
  assign insert = gen_enable && src_active && in_line && (zone != SCG_PASS);

  // The scrambler itself is downstream; stresses appear only with its coding
  always_comb begin
    next_st = st;
    // Active flag travels with its word so the output stays aligned
    next_st.active = src_active;
    // Frame toggle flips once per frame; the new value applies from the next cycle
    if (src_frame_start) begin
      next_st.frame_toggle = ~st.frame_toggle;
    end
    // Pattern word in zone, source word elsewhere
    if (insert) begin
      next_st.word = WORD_W'(pat_word);
    end else begin
      next_st.word = src_word;
    end
  end

  // Registered state; every output comes from here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '{word: WORD_W'(RST_WORD), active: 1'b0, frame_toggle: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register
  assign out_word = st.word;
  assign out_active = st.active;
  assign out_polarity_frame = st.frame_toggle;

endmodule // scg_checkfield_gen

// ---- sim/scg_checker_assertions.sv ----
// Purpose: Port checks for the checkfield generator
// Assumes: Zone checks use the 1125-line layout, field 1
// Notes: Output words lag the sampled inputs by one clock
`timescale 1ns/1ps
module scg_checker
  import scg_pkg::*;
#(parameter int WORD_W = 10) (
  // Clock, reset and configuration
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic gen_enable,
  input wire logic [1:0] format_sel,
  input wire logic [2:0] switch_offset,
  input wire logic eq_swap,
  input wire logic pll_swap,
  // Video in and out
  input wire logic [WORD_W-1:0] src_word,
  input wire logic [10:0] src_line,
  input wire logic [11:0] src_word_pos,
  input wire logic src_active,
  input wire logic src_frame_start,
  input wire logic [WORD_W-1:0] out_word,
  input wire logic out_active,
  input wire logic out_polarity_frame
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Zone decode; PLL zone starts past the widest switch range
  // Words past the end of the line pass through, so they are outside every zone
  wire logic on = gen_enable && src_active && format_sel == FMT_1125_I
    && src_word_pos <= LAST_WORD_POS;
  wire logic eqz = on && src_line >= F1_FIRST_1125 && src_line <= F1_EQ_LO_1125;
  wire logic pllz = on && src_line > F1_EQ_LO_1125 + 11'h007 && src_line <= F1_LAST_1125;
  wire logic first = eqz && src_line == F1_FIRST_1125 && src_word_pos == POL_WORD_POS;
  wire logic [10:0] sw = F1_EQ_LO_1125 + {8'h00, switch_offset};
  wire logic even = !src_word_pos[0] && !eq_swap && !pll_swap;
  a_eq_chroma: assert property (eqz && even |=> out_word == EQ_CHROMA_WORD)
    else $error("equalizer chroma word wrong");
  a_eq_luma: assert property (eqz && src_word_pos[0] && !first && !eq_swap
    |=> out_word == EQ_LUMA_WORD) else $error("equalizer luma word wrong");
  a_eq_swapped: assert property (eqz && !src_word_pos[0] && eq_swap
    |=> out_word == EQ_LUMA_WORD) else $error("swapped equalizer word wrong");
  a_pll_chroma: assert property (pllz && even |=> out_word == PLL_CHROMA_WORD)
    else $error("PLL chroma word wrong");
  a_pol_word: assert property (first && out_polarity_frame
    |=> out_word == ($past(eq_swap) ? POL_WORD_SWAPPED : POL_WORD)) else $error("no pol word");
  a_pol_absent: assert property (first && !out_polarity_frame && !eq_swap
    |=> out_word == EQ_LUMA_WORD) else $error("pol word on wrong frame");
  a_frame_toggle: assert property (src_frame_start
    |=> out_polarity_frame != $past(out_polarity_frame)) else $error("frame bit stuck");
  a_switch_line: assert property (on && even && (src_line == sw || src_line == sw + 11'h001)
    |=> out_word == ($past(src_line) == sw ? EQ_CHROMA_WORD : PLL_CHROMA_WORD))
    else $error("switch line wrong");
  a_pass_words: assert property (!src_active || !gen_enable || (on && src_line > F1_LAST_1125
    && src_line < F2_FIRST_1125) |=> out_word == $past(src_word)) else $error("no pass");
  a_active_copy: assert property (1'b1 |=> out_active == $past(src_active))
    else $error("active flag wrong");
  c_pol: cover property (first && out_polarity_frame);
  c_pll: cover property (pllz);
  c_frame: cover property (src_frame_start);
endmodule // scg_checker

// ---- sim/scg_serial_sink.sv ----
// Purpose: Far-side channel coder model
// Assumes: Ten bits per word, least significant bit first
// Notes: Behavioural; the line level is observed only
`timescale 1ns/1ps
module scg_serial_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Word in, line level out
  input wire logic [9:0] word,
  output logic line_level
);
  logic [8:0] scr;
  // Scrambler then NRZI, a whole word per clock
  always @(posedge clk_sys) begin : coder
    logic [8:0] s;
    logic l;
    logic b;
    s = scr;
    l = line_level;
    for (int i = 0; i < 10; i++) begin
      b = word[i] ^ s[8] ^ s[3];
      s = {s[7:0], b};
      l = l ^ b;
    end
    scr <= sys_rst ? 9'h000 : s;
    line_level <= sys_rst ? 1'b0 : l;
  end
endmodule // scg_serial_sink

// ---- sim/scg_checkfield_gen_tb.sv ----
// Purpose: Directed bench for the checkfield generator
// Assumes: 40 MHz clock, inputs moved 1 ns after the edge
// Notes: Each word is judged one clock after it is applied
`timescale 1ns/1ps
module scg_checkfield_gen_tb
  import scg_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, gen_enable = 1'b1, eq_swap = 1'b0, pll_swap = 1'b0;
  logic src_active = 1'b0, src_frame_start = 1'b0;
  logic [1:0] format_sel = FMT_1125_I;
  logic [2:0] switch_offset = 3'h7;
  logic [9:0] src_word = 10'h2A5;
  logic [10:0] src_line = 11'h001;
  logic [11:0] src_word_pos = 12'h000;
  logic [9:0] out_word;
  logic out_active, out_polarity_frame, line_level;
  int mismatches = 0;
  int check_count = 0;
  localparam logic [10:0] FL [4] = '{F1_FIRST_1125, F1_FIRST_1250, F1_FIRST_1080I, FIRST_1080P};
  localparam logic [10:0] LL [4] = '{F1_LAST_1125, F1_LAST_1250, F1_LAST_1080I, LAST_1080P};
  always #12.5 clk_sys = ~clk_sys;
  scg_checkfield_gen #(.WORD_W(10)) scg_checkfield_gen_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .gen_enable(gen_enable), .format_sel(format_sel),
    .switch_offset(switch_offset), .eq_swap(eq_swap), .pll_swap(pll_swap),
    .src_word(src_word), .src_line(src_line), .src_word_pos(src_word_pos),
    .src_active(src_active), .src_frame_start(src_frame_start), .out_word(out_word),
    .out_active(out_active), .out_polarity_frame(out_polarity_frame));
  scg_serial_sink scg_serial_sink_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .word(out_word), .line_level(line_level));
  task automatic conclude;
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One active word, judged after the next edge
  task automatic chk(input logic [10:0] ln, input logic [11:0] ps, input logic [9:0] e);
    src_line = ln;
    src_word_pos = ps;
    src_active = 1'b1;
    @(posedge clk_sys);
    #1;
    cmp("out_word", e, out_word);
    cmp("out_active", 10'h001, {9'h000, out_active});
  endtask
  task automatic pulse(input logic [9:0] e);
    src_frame_start = 1'b1;
    src_active = 1'b0;
    @(posedge clk_sys);
    #1;
    src_frame_start = 1'b0;
    cmp("out_polarity_frame", e, {9'h000, out_polarity_frame});
  endtask
  task automatic t_patterns;
    chk(11'h02A, 12'h000, EQ_CHROMA_WORD);
    chk(11'h02A, LAST_WORD_POS, EQ_LUMA_WORD);
    chk(11'h02A, LAST_WORD_POS + 12'h001, 10'h2A5);
    chk(F1_LAST_1125, 12'h002, PLL_CHROMA_WORD);
    chk(F1_LAST_1125, 12'h003, PLL_LUMA_WORD);
    chk(F1_LAST_1125 + 11'h001, 12'h000, 10'h2A5);
    chk(F2_FIRST_1125, 12'h000, EQ_CHROMA_WORD);
    chk(F2_LAST_1125, 12'h001, PLL_LUMA_WORD);
  endtask
  // Same offset must move both fields' switch line
  task automatic t_switch(input logic [2:0] o);
    switch_offset = o;
    chk(F1_EQ_LO_1125 + {8'h00, o}, 12'h000, EQ_CHROMA_WORD);
    chk(F1_EQ_LO_1125 + {8'h00, o} + 11'h001, 12'h000, PLL_CHROMA_WORD);
    chk(F2_EQ_LO_1125 + {8'h00, o}, 12'h000, EQ_CHROMA_WORD);
    chk(F2_EQ_LO_1125 + {8'h00, o} + 11'h001, 12'h000, PLL_CHROMA_WORD);
  endtask
  task automatic t_polarity;
    pulse(10'h001);
    chk(F1_FIRST_1125, POL_WORD_POS, POL_WORD);
    chk(F1_FIRST_1125, 12'h003, EQ_LUMA_WORD);
    pulse(10'h000);
    chk(F1_FIRST_1125, POL_WORD_POS, EQ_LUMA_WORD);
  endtask
  task automatic t_swap;
    eq_swap = 1'b1;
    pll_swap = 1'b1;
    pulse(10'h001);
    chk(F1_FIRST_1125, POL_WORD_POS, POL_WORD_SWAPPED);
    chk(11'h02A, 12'h002, EQ_LUMA_WORD);
    chk(11'h02A, 12'h003, EQ_CHROMA_WORD);
    chk(F1_LAST_1125, 12'h000, PLL_LUMA_WORD);
    eq_swap = 1'b0;
    pll_swap = 1'b0;
    pulse(10'h000);
  endtask
  task automatic t_formats;
    for (int i = 1; i < 4; i++) begin
      format_sel = 2'(i);
      chk(FL[i], 12'h000, EQ_CHROMA_WORD);
      chk(FL[i] - 11'h001, 12'h000, 10'h2A5);
      chk(LL[i], 12'h000, PLL_CHROMA_WORD);
      chk(LL[i] + 11'h001, 12'h000, 10'h2A5);
    end
    format_sel = FMT_1125_I;
  endtask
  task automatic t_pass;
    src_word = 10'h155;
    @(posedge clk_sys);
    #1;
    cmp("out_word", 10'h155, out_word);
    gen_enable = 1'b0;
    chk(11'h02A, 12'h000, 10'h155);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    cmp("out_word", RST_WORD, out_word);
    sys_rst = 1'b0;
    t_patterns();
    t_switch(3'h3);
    t_switch(3'h7);
    t_polarity();
    t_swap();
    t_formats();
    t_pass();
    conclude();
  end
  // Run needs about 50 clocks; cut off well beyond
  initial begin
    #(25 * 2000);
    mismatches++;
    conclude();
  end
endmodule // scg_checkfield_gen_tb
bind scg_checkfield_gen scg_checker #(.WORD_W(WORD_W)) scg_checker_inst (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .gen_enable(gen_enable), .format_sel(format_sel),
  .switch_offset(switch_offset), .eq_swap(eq_swap), .pll_swap(pll_swap),
  .src_word(src_word), .src_line(src_line), .src_word_pos(src_word_pos),
  .src_active(src_active), .src_frame_start(src_frame_start), .out_word(out_word),
  .out_active(out_active), .out_polarity_frame(out_polarity_frame));
